// [pss_pkg.sv]
// shared constants for the start-up supervisor
package pss_pkg;
    // system clock rate
    localparam int unsigned CLK_MHZ = 50;

    // durations in their own units
    localparam int unsigned TIMEOUT_US = 100_000;
    localparam int unsigned MAINS_LOSS_US = 64_000;
    localparam int unsigned SOFT_START_US = 130_000;
    localparam int unsigned IDLE_DEB_NS = 1_800;
    localparam int unsigned DIS_DEB_US = 50;
    localparam int unsigned BI_SHORT_US = 1_000;
    localparam int unsigned BI_LONG_US = 40_000;
    localparam int unsigned BO_US = 630_000;

    // derived cycle counts, least times rounded up
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
    localparam int unsigned MAINS_LOSS_CYC = MAINS_LOSS_US * CLK_MHZ;
    localparam int unsigned SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
    localparam int unsigned IDLE_DEB_CYC = (IDLE_DEB_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DIS_DEB_CYC = DIS_DEB_US * CLK_MHZ;
    localparam int unsigned BI_SHORT_CYC = BI_SHORT_US * CLK_MHZ;
    localparam int unsigned BI_LONG_CYC = BI_LONG_US * CLK_MHZ;
    localparam int unsigned BO_CYC = BO_US * CLK_MHZ;

    // counter and ramp widths
    localparam int unsigned CNT_W = 26;
    localparam int unsigned OCP_W = 8;
    localparam logic [7:0] OCP_ZERO = 8'h00;
    localparam logic [7:0] OCP_FULL = 8'hff;

    // qualification timer channels
    localparam int unsigned NUM_TMR = 6;
    localparam int unsigned TMR_IDLE = 0;
    localparam int unsigned TMR_DIS = 1;
    localparam int unsigned TMR_BI = 2;
    localparam int unsigned TMR_BO = 3;
    localparam int unsigned TMR_MAINS = 4;
    localparam int unsigned TMR_TOUT = 5;

    // one-hot supervisor states
    typedef enum logic [8:0] {
        ST_OFF = 9'h001,
        ST_CHARGE = 9'h002,
        ST_BI_WAIT = 9'h004,
        ST_RUN = 9'h008,
        ST_BURST = 9'h010,
        ST_IDLE = 9'h020,
        ST_DISABLE = 9'h040,
        ST_BROWNOUT = 9'h080,
        ST_DISCHARGE = 9'h100
    } pss_state_e;
endpackage

// [pss_if.sv]
// carriers between the supervisor and its timer and ramp
`timescale 1ns/1ps
interface pss_tmr_if;
    logic cond;
    logic [pss_pkg::CNT_W-1:0] limit;
    logic done;
    modport user (output cond, output limit, input done);
    modport timer (input cond, input limit, output done);
endinterface

interface pss_ramp_if;
    logic start;
    logic [pss_pkg::OCP_W-1:0] code;
    logic full;
    modport user (output start, input code, input full);
    modport ramp (input start, output code, output full);
endinterface

// [pss_timer.sv]
// qualification timer: done once cond has held for limit cycles
`timescale 1ns/1ps
module pss_timer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // condition, limit and result
    pss_tmr_if.timer port
);
    logic [pss_pkg::CNT_W-1:0] cnt_q;
    logic done_q;

    // count while the condition holds, restart when it drops
    always_ff @(posedge clk_sys) begin
        if (reset || !port.cond) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else if (cnt_q >= port.limit - pss_pkg::CNT_W'(1)) begin
            done_q <= 1'b1; // RULE21
        end else begin
            cnt_q <= cnt_q + pss_pkg::CNT_W'(1);
        end
    end

    assign port.done = done_q;

    a_timer_cond: assert property (@(posedge clk_sys) disable iff (reset) done_q |-> $past(port.cond)) // RULE21
        else $error("timer done without held condition");
endmodule

// [pss_ramp.sv]
// soft-start ramp of the overcurrent reference code
`timescale 1ns/1ps
module pss_ramp #(
    parameter int unsigned SS_CYCLES = pss_pkg::SOFT_START_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // start pulse and ramp code
    pss_ramp_if.ramp port
);
    localparam int unsigned STEP_CYC = (SS_CYCLES / 255 > 0) ? SS_CYCLES / 255 : 1;
    logic [pss_pkg::CNT_W-1:0] div_q;
    logic [pss_pkg::OCP_W-1:0] code_q;
    logic step;

    assign step = (div_q == pss_pkg::CNT_W'(STEP_CYC - 1));

    // step divider, one enable pulse per ramp step
    always_ff @(posedge clk_sys) begin
        if (reset || port.start || step) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + pss_pkg::CNT_W'(1);
        end
    end

    // ramp from zero to full over the soft-start duration
    always_ff @(posedge clk_sys) begin
        if (reset || port.start) begin
            code_q <= pss_pkg::OCP_ZERO; // RULE7
        end else if (step && code_q != pss_pkg::OCP_FULL) begin
            code_q <= code_q + pss_pkg::OCP_W'(1); // RULE7
        end
    end

    assign port.code = code_q;
    assign port.full = (code_q == pss_pkg::OCP_FULL);

    a_ramp_restart: assert property (@(posedge clk_sys) disable iff (reset)
        port.start |=> code_q == pss_pkg::OCP_ZERO ##1 code_q <= pss_pkg::OCP_W'(1)) // RULE7
        else $error("soft-start ramp did not restart from zero");
endmodule

// [pss_supervisor.sv]
// start-up, recharge, discharge and mode supervisor of the pfc controller
// Summary of operation
// [RULE1] hv above start: source on, nominal current
// [RULE2] supply shorted: use reduced source current
// [RULE3] run at turn-on; hold source until 70%
// [RULE4] source forced off after start timeout
// [RULE5] supply at turn-off: recharge, restart soft-start
// [RULE6] mains lost: sink until hv safe
// [RULE7] soft-start ramps overcurrent reference to full
// [RULE8] burst stop below level, restart above
// [RULE9] burst stop waits for gate falling
// [RULE10] forced idle: stop, amp off, comp open
// [RULE11] leave idle above hysteresis, no soft-start
// [RULE12] weak then strong feedback pull-up
// [RULE13] idle recharges supply near turn-off
// [RULE14] short idle debounce, long disable debounce
// [RULE15] disable: stop, low power, comp pull-up
// [RULE16] enable threshold: recharge then soft-start
// [RULE17] disabled: supply kept between off and on
// [RULE18] start needs brown-in; brown-in recharges
// [RULE19] short first brown-in debounce, long later
// [RULE20] brownout held qualify time stops switching
// [RULE21] synchronised flags, durations as cycle counts
// [RULE22] mains loss: no activity for whole window
`timescale 1ns/1ps
module pss_supervisor #(
    parameter int unsigned TIMEOUT_CYC = pss_pkg::TIMEOUT_CYC,
    parameter int unsigned MAINS_LOSS_CYC = pss_pkg::MAINS_LOSS_CYC,
    parameter int unsigned SOFT_START_CYC = pss_pkg::SOFT_START_CYC,
    parameter int unsigned IDLE_DEB_CYC = pss_pkg::IDLE_DEB_CYC,
    parameter int unsigned DIS_DEB_CYC = pss_pkg::DIS_DEB_CYC,
    parameter int unsigned BI_SHORT_CYC = pss_pkg::BI_SHORT_CYC,
    parameter int unsigned BI_LONG_CYC = pss_pkg::BI_LONG_CYC,
    parameter int unsigned BO_CYC = pss_pkg::BO_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // high-voltage and supply comparator flags
    input wire logic hv_above_start,
    input wire logic hv_above_safe,
    input wire logic vcc_above_short,
    input wire logic vcc_at_on,
    input wire logic vcc_below_off,
    input wire logic vcc_near_off,
    // feedback comparator flags
    input wire logic fb_above_seventy,
    input wire logic fb_below_idle,
    input wire logic fb_above_idle_hyst,
    input wire logic fb_at_ref,
    // compensation comparator flags
    input wire logic comp_below_burst,
    input wire logic comp_above_restart,
    input wire logic comp_below_disable,
    input wire logic comp_above_enable,
    // line sensing and gate
    input wire logic line_above_brown_in,
    input wire logic line_below_brownout,
    input wire logic line_activity,
    input wire logic gate_output,
    // enables and overcurrent reference code toward the analogue blocks
    output logic switch_en_q,
    output logic src_en_q,
    output logic src_reduced_q,
    output logic discharge_q,
    output logic err_amp_en_q,
    output logic comp_high_z_q,
    output logic comp_pullup_en_q,
    output logic fb_pullup_weak_q,
    output logic fb_pullup_strong_q,
    output logic low_power_q,
    output logic [pss_pkg::OCP_W-1:0] first_overcurrent_comparator_ref_q
);
    pss_pkg::pss_state_e state_q, state_d;
    logic started_q;
    logic hv_hold_q;
    logic recharge_q;
    logic fb_boost_q;
    logic ss_start;
    logic [pss_pkg::NUM_TMR-1:0] tmr_cond;
    logic [pss_pkg::NUM_TMR-1:0] tmr_done;
    logic [pss_pkg::CNT_W-1:0] tmr_lim [pss_pkg::NUM_TMR];
    logic run_like;
    logic mains_lost;

    pss_tmr_if tif [pss_pkg::NUM_TMR] ();
    pss_ramp_if rif ();

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    assign run_like = (state_q == pss_pkg::ST_RUN) || (state_q == pss_pkg::ST_BURST);
    assign mains_lost = tmr_done[pss_pkg::TMR_MAINS] && hv_above_safe;

    // timer conditions and limits
    assign tmr_cond[pss_pkg::TMR_IDLE] = fb_below_idle; // RULE14
    assign tmr_cond[pss_pkg::TMR_DIS] = comp_below_disable; // RULE14
    assign tmr_cond[pss_pkg::TMR_BI] = line_above_brown_in;
    assign tmr_cond[pss_pkg::TMR_BO] = line_below_brownout && run_like; // RULE20
    assign tmr_cond[pss_pkg::TMR_MAINS] = !line_activity; // RULE22
    assign tmr_cond[pss_pkg::TMR_TOUT] = hv_hold_q; // RULE4
    assign tmr_lim[pss_pkg::TMR_IDLE] = pss_pkg::CNT_W'(IDLE_DEB_CYC);
    assign tmr_lim[pss_pkg::TMR_DIS] = pss_pkg::CNT_W'(DIS_DEB_CYC);
    assign tmr_lim[pss_pkg::TMR_BI] = started_q ? pss_pkg::CNT_W'(BI_LONG_CYC)
                                                : pss_pkg::CNT_W'(BI_SHORT_CYC); // RULE19
    assign tmr_lim[pss_pkg::TMR_BO] = pss_pkg::CNT_W'(BO_CYC);
    assign tmr_lim[pss_pkg::TMR_MAINS] = pss_pkg::CNT_W'(MAINS_LOSS_CYC);
    assign tmr_lim[pss_pkg::TMR_TOUT] = pss_pkg::CNT_W'(TIMEOUT_CYC);

    // one qualification timer per channel
    for (genvar g = 0; g < pss_pkg::NUM_TMR; g++) begin : g_tmr
        assign tif[g].cond = tmr_cond[g];
        assign tif[g].limit = tmr_lim[g];
        assign tmr_done[g] = tif[g].done;
        pss_timer u_tmr (
            .clk_sys(clk_sys),
            .reset(reset),
            .port(tif[g])
        );
    end

    // soft-start ramp
    assign rif.start = ss_start;
    pss_ramp #(
        .SS_CYCLES(SOFT_START_CYC)
    ) u_ramp (
        .clk_sys(clk_sys),
        .reset(reset),
        .port(rif)
    );

    // next state
    always_comb begin
        state_d = state_q;
        ss_start = 1'b0;
        if (mains_lost && state_q != pss_pkg::ST_DISCHARGE) begin
            state_d = pss_pkg::ST_DISCHARGE; // RULE6
        end else begin
            case (state_q)
                pss_pkg::ST_OFF: begin
                    if (hv_above_start) begin
                        state_d = pss_pkg::ST_CHARGE; // RULE1
                    end
                end
                pss_pkg::ST_CHARGE: begin
                    if (vcc_at_on) begin
                        state_d = pss_pkg::ST_BI_WAIT;
                    end
                end
                pss_pkg::ST_BI_WAIT: begin
                    if (vcc_below_off) begin
                        state_d = pss_pkg::ST_CHARGE;
                    end else if (tmr_done[pss_pkg::TMR_BI]) begin
                        state_d = pss_pkg::ST_RUN; // RULE18
                        ss_start = 1'b1; // RULE3
                    end
                end
                pss_pkg::ST_RUN: begin
                    if (vcc_below_off) begin
                        state_d = pss_pkg::ST_CHARGE; // RULE5
                    end else if (tmr_done[pss_pkg::TMR_DIS]) begin
                        state_d = pss_pkg::ST_DISABLE; // RULE15
                    end else if (tmr_done[pss_pkg::TMR_IDLE]) begin
                        state_d = pss_pkg::ST_IDLE; // RULE10
                    end else if (tmr_done[pss_pkg::TMR_BO]) begin
                        state_d = pss_pkg::ST_BROWNOUT; // RULE20
                    end else if (comp_below_burst && !gate_output) begin
                        state_d = pss_pkg::ST_BURST; // RULE8 RULE9
                    end
                end
                pss_pkg::ST_BURST: begin
                    if (vcc_below_off) begin
                        state_d = pss_pkg::ST_CHARGE; // RULE5
                    end else if (tmr_done[pss_pkg::TMR_DIS]) begin
                        state_d = pss_pkg::ST_DISABLE;
                    end else if (tmr_done[pss_pkg::TMR_BO]) begin
                        state_d = pss_pkg::ST_BROWNOUT;
                    end else if (comp_above_restart) begin
                        state_d = pss_pkg::ST_RUN; // RULE8
                    end
                end
                pss_pkg::ST_IDLE: begin
                    if (tmr_done[pss_pkg::TMR_DIS]) begin
                        state_d = pss_pkg::ST_DISABLE;
                    end else if (fb_above_idle_hyst) begin
                        state_d = pss_pkg::ST_RUN; // RULE11
                    end
                end
                pss_pkg::ST_DISABLE: begin
                    if (comp_above_enable) begin
                        state_d = pss_pkg::ST_CHARGE; // RULE16
                    end
                end
                pss_pkg::ST_BROWNOUT: begin
                    if (tmr_done[pss_pkg::TMR_BI]) begin
                        state_d = pss_pkg::ST_CHARGE; // RULE18
                    end
                end
                pss_pkg::ST_DISCHARGE: begin
                    if (!hv_above_safe) begin
                        state_d = pss_pkg::ST_OFF; // RULE6
                    end
                end
                default: begin
                    state_d = pss_pkg::ST_OFF;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= pss_pkg::ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // first start marker for the brown-in debounce choice
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            started_q <= 1'b0;
        end else if (ss_start) begin
            started_q <= 1'b1; // RULE19
        end
    end

    // start-up source hold after operation begins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hv_hold_q <= 1'b0;
        end else if (ss_start) begin
            hv_hold_q <= 1'b1; // RULE3
        end else if (fb_above_seventy || tmr_done[pss_pkg::TMR_TOUT] || !run_like) begin
            hv_hold_q <= 1'b0; // RULE3 RULE4
        end
    end

    // hysteretic recharge in idle and disable
    always_ff @(posedge clk_sys) begin
        if (reset || state_d != state_q) begin
            recharge_q <= 1'b0;
        end else if (state_q == pss_pkg::ST_IDLE && vcc_near_off) begin
            recharge_q <= 1'b1; // RULE13
        end else if (state_q == pss_pkg::ST_DISABLE && vcc_below_off) begin
            recharge_q <= 1'b1; // RULE17
        end else if (vcc_at_on) begin
            recharge_q <= 1'b0; // RULE17
        end
    end

    // strong feedback pull-up until the reference is reached
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fb_boost_q <= 1'b0;
        end else if (state_q == pss_pkg::ST_IDLE && fb_above_idle_hyst) begin
            fb_boost_q <= 1'b1; // RULE12
        end else if (fb_at_ref || state_q != pss_pkg::ST_RUN) begin
            fb_boost_q <= 1'b0; // RULE12
        end
    end

    // registered enables
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            switch_en_q <= 1'b0;
            src_en_q <= 1'b0;
            src_reduced_q <= 1'b0;
            discharge_q <= 1'b0;
            err_amp_en_q <= 1'b0;
            comp_high_z_q <= 1'b0;
            comp_pullup_en_q <= 1'b0;
            fb_pullup_weak_q <= 1'b0;
            fb_pullup_strong_q <= 1'b0;
            low_power_q <= 1'b0;
        end else begin
            switch_en_q <= (state_q == pss_pkg::ST_RUN);
            src_en_q <= (state_q == pss_pkg::ST_CHARGE) || (state_q == pss_pkg::ST_DISCHARGE)
                        || (run_like && hv_hold_q) || recharge_q; // RULE1 RULE6 RULE13 RULE17
            src_reduced_q <= (state_q != pss_pkg::ST_DISCHARGE) && !vcc_above_short; // RULE2
            discharge_q <= (state_q == pss_pkg::ST_DISCHARGE); // RULE6
            err_amp_en_q <= run_like; // RULE10 RULE15
            comp_high_z_q <= (state_q == pss_pkg::ST_IDLE); // RULE10
            comp_pullup_en_q <= (state_q == pss_pkg::ST_DISABLE); // RULE15
            fb_pullup_weak_q <= (state_q == pss_pkg::ST_IDLE) && !fb_above_idle_hyst; // RULE12
            fb_pullup_strong_q <= fb_boost_q || (state_q == pss_pkg::ST_IDLE && fb_above_idle_hyst); // RULE12
            low_power_q <= (state_q == pss_pkg::ST_BURST) || (state_q == pss_pkg::ST_IDLE)
                           || (state_q == pss_pkg::ST_DISABLE); // RULE8 RULE15
        end
    end

    // overcurrent reference copied from the ramp register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            first_overcurrent_comparator_ref_q <= pss_pkg::OCP_ZERO;
        end else begin
            first_overcurrent_comparator_ref_q <= rif.code; // RULE7
        end
    end

    sequence s_enter_run;
        state_q == pss_pkg::ST_BI_WAIT ##1 state_q == pss_pkg::ST_RUN;
    endsequence

    a_charge_source: assert property (state_q == pss_pkg::ST_CHARGE |=> src_en_q) // RULE1
        else $error("source off while charging");
    a_short_level: assert property (!vcc_above_short && state_q != pss_pkg::ST_DISCHARGE
        |=> src_reduced_q) // RULE2
        else $error("reduced level not chosen");
    a_run_hold: assert property (s_enter_run |-> hv_hold_q ##1 src_en_q) // RULE3
        else $error("source not held after start");
    a_timeout_off: assert property (tmr_done[pss_pkg::TMR_TOUT] |=> !hv_hold_q) // RULE4
        else $error("source hold past timeout");
    a_supply_drop: assert property (state_q == pss_pkg::ST_RUN && vcc_below_off && !mains_lost
        |=> state_q == pss_pkg::ST_CHARGE ##1 src_en_q) // RULE5
        else $error("no recharge after supply drop");
    a_discharge_sink: assert property (mains_lost |=> state_q == pss_pkg::ST_DISCHARGE ##1 discharge_q && src_en_q) // RULE6
        else $error("discharge not started");
    a_burst_gate: assert property (state_q == pss_pkg::ST_RUN && gate_output |=> state_q != pss_pkg::ST_BURST) // RULE9
        else $error("burst stop during on-time");
    a_idle_outputs: assert property (state_q == pss_pkg::ST_IDLE
        |=> comp_high_z_q && !err_amp_en_q && !switch_en_q) // RULE10
        else $error("idle outputs wrong");
    a_idle_exit: assert property (state_q == pss_pkg::ST_IDLE && fb_above_idle_hyst && !mains_lost
        && !tmr_done[pss_pkg::TMR_DIS] |=> state_q == pss_pkg::ST_RUN && !$past(ss_start)) // RULE11
        else $error("idle exit wrong");
    a_disable_pull: assert property (state_q == pss_pkg::ST_DISABLE |=> comp_pullup_en_q && low_power_q) // RULE15
        else $error("disable outputs wrong");
endmodule

// [pss_partner.sv]
// behavioural model of supply capacitor, high-voltage line and gate driver
`timescale 1ns/1ps
module pss_partner (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // enables from the supervisor
    input wire logic src_en_q,
    input wire logic discharge_q,
    input wire logic switch_en_q,
    // scenario controls
    input wire logic mains_on,
    input wire logic aux_fail,
    input wire logic vcc_short,
    input wire logic gate_stuck,
    // comparator flags and gate level
    output logic hv_above_start,
    output logic hv_above_safe,
    output logic vcc_above_short,
    output logic vcc_at_on,
    output logic vcc_below_off,
    output logic vcc_near_off,
    output logic line_activity,
    output logic gate_output
);
    int vcc, hv;
    logic [3:0] cnt;
    // supply: source charges, aux winding holds, otherwise slow drain
    always_ff @(posedge clk_sys) begin
        cnt <= reset ? 4'h0 : cnt + 4'h1;
        if (reset || vcc_short) begin
            vcc <= 0;
        end else if (aux_fail) begin
            vcc <= (vcc > 0) ? vcc - 1 : 0;
        end else if (src_en_q && !discharge_q) begin
            vcc <= (vcc < 150) ? vcc + 1 : vcc;
        end else if (switch_en_q) begin
            vcc <= 120;
        end else if (cnt[2:0] == 3'h0 && vcc > 0) begin
            vcc <= vcc - 1;
        end
    end
    // line: mains holds it high, the sink pulls it down
    always_ff @(posedge clk_sys) begin
        if (reset || mains_on) begin
            hv <= reset ? 0 : 300;
        end else if (discharge_q) begin
            hv <= (hv > 5) ? hv - 5 : 0;
        end
    end
    // comparator flags, activity pulses only while mains present
    assign hv_above_start = hv > 29;
    assign hv_above_safe = hv > 45;
    assign vcc_above_short = !vcc_short && vcc > 10;
    assign vcc_at_on = vcc >= 140;
    assign vcc_below_off = vcc <= 100;
    assign vcc_near_off = vcc <= 105;
    assign line_activity = mains_on && cnt == 4'h0;
    assign gate_output = gate_stuck || (switch_en_q && cnt[1]);
endmodule

// [testbench.sv]
// scenario bench for the start-up supervisor
`timescale 1ns/1ps
module testbench;
    localparam int TO = 300, ML = 200, IDB = 8, DDB = 20, BIS = 30, BIL = 80, BO = 40;
    bit clk_sys;
    logic reset = 1'b1;
    bit fb_above_seventy, fb_below_idle, fb_above_idle_hyst, fb_at_ref;
    bit comp_below_burst, comp_above_restart, comp_below_disable, comp_above_enable;
    bit line_above_brown_in, line_below_brownout;
    bit mains_on, aux_fail, gate_stuck, vcc_short = 1'b1;
    logic hv_above_start, hv_above_safe, vcc_above_short, vcc_at_on, vcc_below_off, vcc_near_off;
    logic line_activity, gate_output, switch_en_q, src_en_q, src_reduced_q, discharge_q, err_amp_en_q;
    logic comp_high_z_q, comp_pullup_en_q, fb_pullup_weak_q, fb_pullup_strong_q, low_power_q;
    logic [pss_pkg::OCP_W-1:0] first_overcurrent_comparator_ref_q;
    logic [9:0] obs;
    int n_fail;
    int comparisons;
    // observed enables, index 0 is switching
    assign obs = {low_power_q, fb_pullup_strong_q, fb_pullup_weak_q, comp_pullup_en_q, comp_high_z_q,
        err_amp_en_q, discharge_q, src_reduced_q, src_en_q, switch_en_q};
    pss_supervisor #(.TIMEOUT_CYC(TO), .MAINS_LOSS_CYC(ML), .SOFT_START_CYC(255), .IDLE_DEB_CYC(IDB),
        .DIS_DEB_CYC(DDB), .BI_SHORT_CYC(BIS), .BI_LONG_CYC(BIL), .BO_CYC(BO)) dut (.*);
    pss_partner far (.*);
    task automatic end_of_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // bounded wait for one enable to reach a level
    task automatic await(int idx, logic val, int bound, string name);
        @(negedge clk_sys);
        for (int i = 0; i < bound && obs[idx] !== val; i++) @(negedge clk_sys);
        check(name, {7'h00, obs[idx]}, {7'h00, val});
        if (obs[idx] !== val) end_of_test();
    endtask
    // one enable must hold its level for n cycles
    task automatic stay(int idx, logic val, int n, string name);
        logic ok = 1'b1;
        repeat (n) begin
            @(negedge clk_sys);
            if (obs[idx] !== val) ok = 1'b0;
        end
        check(name, {7'h00, ok}, 8'h01);
    endtask
    task automatic t_start();
        @(negedge clk_sys);
        check("outs after reset", {obs[7:0] | first_overcurrent_comparator_ref_q}, 8'h04);
        @(posedge clk_sys) mains_on <= 1'b1;
        await(1, 1'b1, 10, "src on");
        check("reduced level", {7'h00, src_reduced_q}, 8'h01);
        @(posedge clk_sys) vcc_short <= 1'b0;
        await(2, 1'b0, 20, "nominal level");
        stay(0, 1'b0, 200, "no early run");
        @(posedge clk_sys) line_above_brown_in <= 1'b1;
        await(0, 1'b1, 400, "run after brown-in");
        check("ramp from zero", {7'h00, first_overcurrent_comparator_ref_q < 8'h03}, 8'h01);
        check("amp on", {7'h00, err_amp_en_q}, 8'h01);
        stay(1, 1'b1, 100, "src held");
        check("ramp part way", {7'h00, first_overcurrent_comparator_ref_q < 8'hff}, 8'h01);
        stay(1, 1'b1, TO - 110, "src held to timeout");
        check("ramp full", first_overcurrent_comparator_ref_q, 8'hff);
        await(1, 1'b0, 20, "timeout off");
        $display("start-up test done");
    endtask
    task automatic t_burst();
        @(posedge clk_sys);
        gate_stuck <= 1'b1;
        comp_below_burst <= 1'b1;
        stay(0, 1'b1, 20, "on-time finished");
        @(posedge clk_sys) gate_stuck <= 1'b0;
        await(0, 1'b0, 10, "burst stop");
        check("burst low power", {7'h00, low_power_q}, 8'h01);
        @(posedge clk_sys);
        comp_below_burst <= 1'b0;
        comp_above_restart <= 1'b1;
        await(0, 1'b1, 10, "burst restart");
        check("burst keeps ramp", first_overcurrent_comparator_ref_q, 8'hff);
        @(posedge clk_sys) comp_above_restart <= 1'b0;
        $display("burst test done");
    endtask
    task automatic t_idle();
        @(posedge clk_sys) fb_below_idle <= 1'b1;
        repeat (IDB - 3) @(posedge clk_sys);
        fb_below_idle <= 1'b0;
        stay(0, 1'b1, 10, "short idle pulse");
        @(posedge clk_sys) fb_below_idle <= 1'b1;
        await(0, 1'b0, IDB + 5, "idle stop");
        check("idle outs", {2'b00, obs[9:4]}, 8'h2a);
        await(1, 1'b1, 200, "idle recharge");
        await(1, 1'b0, 80, "idle recharge end");
        @(posedge clk_sys);
        fb_below_idle <= 1'b0;
        fb_above_idle_hyst <= 1'b1;
        await(0, 1'b1, 10, "idle exit");
        check("strong pull-up", {7'h00, fb_pullup_strong_q}, 8'h01);
        check("idle keeps ramp", first_overcurrent_comparator_ref_q, 8'hff);
        @(posedge clk_sys) fb_at_ref <= 1'b1;
        await(8, 1'b0, 10, "pull-up off at ref");
        $display("idle test done");
    endtask
    task automatic t_disable();
        @(posedge clk_sys) comp_below_disable <= 1'b1;
        repeat (DDB - 3) @(posedge clk_sys);
        comp_below_disable <= 1'b0;
        stay(0, 1'b1, 10, "short disable pulse");
        @(posedge clk_sys) comp_below_disable <= 1'b1;
        stay(0, 1'b1, IDB + 4, "disable debounce");
        await(0, 1'b0, DDB, "disable stop");
        check("disable outs", {2'b00, obs[9:4]}, 8'h24);
        await(1, 1'b1, 200, "disable recharge");
        await(1, 1'b0, 80, "disable recharge end");
        @(posedge clk_sys);
        comp_below_disable <= 1'b0;
        comp_above_enable <= 1'b1;
        await(1, 1'b1, 20, "enable recharge");
        await(0, 1'b1, 300, "enable restart");
        check("fresh ramp", {7'h00, first_overcurrent_comparator_ref_q < 8'h03}, 8'h01);
        @(posedge clk_sys);
        comp_above_enable <= 1'b0;
        fb_above_seventy <= 1'b1;
        await(1, 1'b0, 10, "src off at seventy");
        $display("disable test done");
    endtask
    task automatic t_drop();
        @(posedge clk_sys) aux_fail <= 1'b1;
        await(0, 1'b0, 200, "shutdown at off");
        await(1, 1'b1, 5, "recharge after drop");
        @(posedge clk_sys) aux_fail <= 1'b0;
        await(0, 1'b1, 300, "restart after drop");
        check("drop fresh ramp", {7'h00, first_overcurrent_comparator_ref_q < 8'h03}, 8'h01);
        $display("drop test done");
    endtask
    task automatic t_brown();
        @(posedge clk_sys);
        line_below_brownout <= 1'b1;
        line_above_brown_in <= 1'b0;
        stay(0, 1'b1, BO - 5, "brownout qualify");
        await(0, 1'b0, 10, "brownout stop");
        @(posedge clk_sys);
        line_below_brownout <= 1'b0;
        line_above_brown_in <= 1'b1;
        stay(1, 1'b0, BIS + 10, "long brown-in");
        await(1, 1'b1, BIL, "brown-in recharge");
        await(0, 1'b1, 300, "restart after brown-in");
        $display("brown test done");
    endtask
    task automatic t_mains();
        @(posedge clk_sys) mains_on <= 1'b0;
        stay(3, 1'b0, ML - 20, "no early sink");
        await(3, 1'b1, 40, "sink on");
        await(3, 1'b0, 100, "sink until safe");
        check("no switching", {7'h00, switch_en_q}, 8'h00);
        $display("mains test done");
    endtask
    // free-running system clock
    initial forever #10 clk_sys = ~clk_sys;
    // reset then the scenarios in order
    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_start();
        t_burst();
        t_idle();
        t_disable();
        t_drop();
        t_brown();
        t_mains();
        end_of_test();
    end
endmodule
